// file: src/aio_cfg.svh
`ifndef AIO_CFG_SVH
`define AIO_CFG_SVH

`define AIO_ADDR_W 5
`define AIO_OFS_CONFIG 5'h00
`define AIO_OFS_CONTROL 5'h04
`define AIO_OFS_CHANNEL 5'h08
`define AIO_OFS_AO0 5'h0c
`define AIO_OFS_AO1 5'h10
`define AIO_OFS_RESULT 5'h14
`define AIO_OFS_STATUS 5'h18

`define AIO_CFG_MODE_LSB 0
`define AIO_CFG_MODE_MSB 1
`define AIO_CFG_AI_UNI 2
`define AIO_CFG_AO0_UNI 3
`define AIO_CFG_AO1_UNI 4
`define AIO_CTL_SWRST 0
`define AIO_STS_READY 0
`define AIO_STS_MODE_LSB 1
`define AIO_STS_MODE_MSB 2

`define AIO_CODE_W 12
`define AIO_SIGN_BIT 11
`define AIO_CH_W 3
`define AIO_PAIR_W 2
`define AIO_RST_MODE 2'h0
`define AIO_MODE_RSVD 2'h3
`define AIO_RST_CODE 12'h800
`define AIO_ZERO32 32'h0000_0000

`endif

// file: src/aio_pkg.sv
package aio_pkg;

  typedef enum logic [1:0] {
    grounded_single_ended_mode,
    floating_single_ended_mode,
    paired_input_mode
  } input_mode_t;

  typedef struct packed {
    input_mode_t mode;
    logic ai_unipolar;
    logic ao0_unipolar;
    logic ao1_unipolar;
  } aio_config_t;

  typedef struct packed {
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic neg_to_ground;
    logic neg_to_sense;
    logic neg_to_channel;
  } amp_route_t;

endpackage

// file: src/ai_code_format.sv
`timescale 1ns/1ns
`include "aio_cfg.svh"

module ai_code_format #(
  parameter int CODE_W = `AIO_CODE_W
) (
  input wire logic [CODE_W-1:0] raw_i,
  input wire logic unipolar_i,
  output logic [15:0] data_o
);

  // Converter delivers offset binary; bipolar flips the top bit into two's complement
  always_comb begin
    if (unipolar_i) begin
      data_o = {{(16-CODE_W){1'b0}}, raw_i};
    end else begin
      data_o = {{(17-CODE_W){~raw_i[CODE_W-1]}}, raw_i[CODE_W-2:0]};
    end
  end

endmodule

// file: src/analog_io_mode_and_code_control.sv
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "aio_cfg.svh"

//Contract
// - Reset gives grounded single-ended, bipolar input and bipolar outputs.
// - Two output channels, each with its own unipolar or bipolar setting.
// - Bipolar input reports signed codes, -5 V F800 hex, +5 V 7FF hex.
// - Unipolar input reports straight binary, 0 V zero, 10 V FFF hex.
// - Single-ended modes offer eight channels, paired mode only four.
// - Paired mode routes even channel to plus, odd channel to minus.
// - Floating mode ties amplifier minus to common sense pin, not ground.
// - Grounded mode ties amplifier minus to analog ground.
// - Mode and polarity are software set; input-only variant resets inputs only (software reset here; power-up reset also clears output settings).
// - Converter results are twelve bits wide.
module analog_io_mode_and_code_control #(
  parameter int CODE_W = `AIO_CODE_W,
  parameter bit HAS_OUTPUTS = 1'b1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [`AIO_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [CODE_W-1:0] adc_code_i,
  input wire logic adc_valid_i,
  output aio_pkg::amp_route_t amp_route_o,
  output logic [CODE_W-1:0] analog_output_ch0_o,
  output logic [CODE_W-1:0] analog_output_ch1_o,
  output logic result_ready_o
);

  aio_pkg::aio_config_t cfg_reg;
  logic [`AIO_CH_W-1:0] chan_reg;
  logic [15:0] ao0_reg;
  logic [15:0] ao1_reg;
  logic [15:0] result_reg;
  logic ready_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] result_next;
  logic req;
  logic take;
  logic wr_take;
  logic rd_take;
  logic sw_reset;
  aio_pkg::amp_route_t route_next;

  assign req = avs_read_i | avs_write_i;
  // Access completes on the edge where waitrequest is already low
  assign take = ce_i & req & ~wait_reg;
  assign wr_take = take & avs_write_i & avs_byteenable_i[0];
  assign rd_take = take & avs_read_i;
  assign sw_reset = wr_take & (avs_address_i == `AIO_OFS_CONTROL)
                    & avs_writedata_i[`AIO_CTL_SWRST];

  // Output code to converter: two's complement becomes offset binary when bipolar
  function automatic logic [CODE_W-1:0] out_code(input logic [15:0] sw_code,
                                                 input logic unipolar);
    logic [CODE_W-1:0] c;
    c = sw_code[CODE_W-1:0];
    if (unipolar) begin
      out_code = c;
    end else begin
      out_code = {~c[CODE_W-1], c[CODE_W-2:0]};
    end
  endfunction

  ai_code_format #(
    .CODE_W(CODE_W)
  ) u_fmt (
    .raw_i(adc_code_i),
    .unipolar_i(cfg_reg.ai_unipolar),
    .data_o(result_next)
  );

  // Bus handshake: one wait cycle so read data can come from a flop
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_reg <= 1'b1;
    end else if (ce_i) begin
      if (take) begin
        wait_reg <= 1'b1;
      end else if (req) begin
        wait_reg <= 1'b0;
      end else begin
        wait_reg <= 1'b1;
      end
    end
  end

  // Configuration state; software reset shares the power-up defaults
  always_ff @(posedge mclk_i) begin
    if (rst_i || (ce_i && sw_reset)) begin
      cfg_reg.mode <= aio_pkg::input_mode_t'(`AIO_RST_MODE);
      cfg_reg.ai_unipolar <= 1'b0;
      if (HAS_OUTPUTS || rst_i) begin
        cfg_reg.ao0_unipolar <= 1'b0;
        cfg_reg.ao1_unipolar <= 1'b0;
      end
    end else if (wr_take && avs_address_i == `AIO_OFS_CONFIG) begin
      // Reserved mode code is refused so the mux never sees an undefined route
      if (avs_writedata_i[`AIO_CFG_MODE_MSB:`AIO_CFG_MODE_LSB] != `AIO_MODE_RSVD) begin
        cfg_reg.mode <= aio_pkg::input_mode_t'(
          avs_writedata_i[`AIO_CFG_MODE_MSB:`AIO_CFG_MODE_LSB]);
      end
      cfg_reg.ai_unipolar <= avs_writedata_i[`AIO_CFG_AI_UNI];
      if (HAS_OUTPUTS) begin
        cfg_reg.ao0_unipolar <= avs_writedata_i[`AIO_CFG_AO0_UNI];
        cfg_reg.ao1_unipolar <= avs_writedata_i[`AIO_CFG_AO1_UNI];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_reg <= '0;
    end else if (wr_take && avs_address_i == `AIO_OFS_CHANNEL) begin
      chan_reg <= avs_writedata_i[`AIO_CH_W-1:0];
    end
  end

  // Output codes; zero code means mid-scale in bipolar, so reset leaves 0 V out
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ao0_reg <= '0;
      ao1_reg <= '0;
    end else if (HAS_OUTPUTS && wr_take) begin
      if (avs_address_i == `AIO_OFS_AO0) begin
        ao0_reg <= avs_writedata_i[15:0];
      end
      if (avs_address_i == `AIO_OFS_AO1) begin
        ao1_reg <= avs_writedata_i[15:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      analog_output_ch0_o <= `AIO_RST_CODE;
      analog_output_ch1_o <= `AIO_RST_CODE;
    end else if (ce_i) begin
      if (HAS_OUTPUTS) begin
        analog_output_ch0_o <= out_code(ao0_reg, cfg_reg.ao0_unipolar);
        analog_output_ch1_o <= out_code(ao1_reg, cfg_reg.ao1_unipolar);
      end else begin
        analog_output_ch0_o <= '0;
        analog_output_ch1_o <= '0;
      end
    end
  end

  // Conversion result capture; a new result beats the read that clears ready
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_reg <= '0;
      ready_reg <= 1'b0;
    end else if (ce_i) begin
      if (adc_valid_i) begin
        result_reg <= result_next;
        ready_reg <= 1'b1;
      end else if (rd_take && avs_address_i == `AIO_OFS_RESULT) begin
        ready_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_ready_o <= 1'b0;
    end else if (ce_i) begin
      result_ready_o <= ready_reg;
    end
  end

  // Amplifier routing from mode and channel
  always_comb begin
    route_next = '0;
    case (cfg_reg.mode)
      aio_pkg::grounded_single_ended_mode: begin
        route_next.pos_sel = chan_reg;
        route_next.neg_to_ground = 1'b1;
      end
      aio_pkg::floating_single_ended_mode: begin
        route_next.pos_sel = chan_reg;
        route_next.neg_to_sense = 1'b1;
      end
      aio_pkg::paired_input_mode: begin
        // Only the low two channel bits count: four pairs
        route_next.pos_sel = {chan_reg[`AIO_PAIR_W-1:0], 1'b0};
        route_next.neg_sel = {chan_reg[`AIO_PAIR_W-1:0], 1'b1};
        route_next.neg_to_channel = 1'b1;
      end
      default: begin
        route_next.neg_to_ground = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      amp_route_o <= '0;
      amp_route_o.neg_to_ground <= 1'b1;
    end else if (ce_i) begin
      amp_route_o <= route_next;
    end
  end

  always_comb begin
    rdata_next = `AIO_ZERO32;
    case (avs_address_i)
      `AIO_OFS_CONFIG: begin
        rdata_next[`AIO_CFG_MODE_MSB:`AIO_CFG_MODE_LSB] = cfg_reg.mode;
        rdata_next[`AIO_CFG_AI_UNI] = cfg_reg.ai_unipolar;
        rdata_next[`AIO_CFG_AO0_UNI] = cfg_reg.ao0_unipolar;
        rdata_next[`AIO_CFG_AO1_UNI] = cfg_reg.ao1_unipolar;
      end
      `AIO_OFS_CHANNEL: rdata_next[`AIO_CH_W-1:0] = chan_reg;
      `AIO_OFS_AO0: rdata_next[15:0] = HAS_OUTPUTS ? ao0_reg : 16'h0000;
      `AIO_OFS_AO1: rdata_next[15:0] = HAS_OUTPUTS ? ao1_reg : 16'h0000;
      `AIO_OFS_RESULT: rdata_next[15:0] = result_reg;
      `AIO_OFS_STATUS: begin
        rdata_next[`AIO_STS_READY] = ready_reg;
        rdata_next[`AIO_STS_MODE_MSB:`AIO_STS_MODE_LSB] = amp_route_o.neg_to_channel ?
          2'h2 : (amp_route_o.neg_to_sense ? 2'h1 : 2'h0);
      end
      default: rdata_next = `AIO_ZERO32;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg <= `AIO_ZERO32;
    end else if (ce_i && req && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

endmodule

// file: test/aio_properties.sv
`timescale 1ns/1ns
module aio_properties #(
  parameter int CODE_W = 12
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic adc_valid_i,
  input wire aio_pkg::amp_route_t amp_route_o,
  input wire logic [CODE_W-1:0] analog_output_ch0_o,
  input wire logic [CODE_W-1:0] analog_output_ch1_o,
  input wire logic result_ready_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  sequence bus_req_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence reset_left_s;
    $fell(rst_i);
  endsequence
  chk_wait_answer: assert property (bus_req_s |=> !avs_waitrequest_o)
    else $error("waitrequest did not drop");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_reset_route: assert property (reset_left_s |-> amp_route_o == 9'h004)
    else $error("route not grounded after reset");
  chk_reset_outs: assert property (reset_left_s |-> analog_output_ch0_o == 12'h800
    && analog_output_ch1_o == 12'h800)
    else $error("outputs not mid code after reset");
  chk_neg_single: assert property ($onehot({amp_route_o.neg_to_ground,
    amp_route_o.neg_to_sense, amp_route_o.neg_to_channel}))
    else $error("amplifier minus not on exactly one source");
  chk_pair_route: assert property (amp_route_o.neg_to_channel |->
    !amp_route_o.pos_sel[0] && amp_route_o.neg_sel == amp_route_o.pos_sel + 3'h1)
    else $error("paired route not even plus odd");
  chk_ready_late: assert property (adc_valid_i |-> ##2 result_ready_o)
    else $error("ready did not follow conversion");
  chk_out_cause: assert property (!$stable(analog_output_ch0_o)
    || !$stable(analog_output_ch1_o) |-> $past(avs_write_i, 2))
    else $error("output changed without a write");
endmodule
bind analog_io_mode_and_code_control aio_properties #(.CODE_W(CODE_W)) chk_u (.mclk_i,
  .rst_i, .ce_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .adc_valid_i, .amp_route_o,
  .analog_output_ch0_o, .analog_output_ch1_o, .result_ready_o);

// file: test/adc_source_model.sv
`timescale 1ns/1ns
module adc_source_model (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [11:0] level_i,
  output logic [11:0] adc_code_o,
  output logic adc_valid_o
);
  // Outside the pulse the code toggles, so a stale capture cannot pass
  always_ff @(posedge mclk_i) begin
    adc_valid_o <= go_i;
    adc_code_o <= go_i ? level_i : ~adc_code_o;
  end
endmodule

// file: test/test_analog_io_mode_and_code_control.sv
`timescale 1ns/1ns
module test_analog_io_mode_and_code_control;
  logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic wt, vld, rready;
  logic [4:0] adr = 5'h00;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [11:0] lvl = 12'h000, code, out0, out1;
  aio_pkg::amp_route_t route;
  int failures = 0, compares = 0;
  analog_io_mode_and_code_control dut_u (.mclk_i, .rst_i, .ce_i, .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .adc_code_i(code), .adc_valid_i(vld),
    .amp_route_o(route), .analog_output_ch0_o(out0), .analog_output_ch1_o(out1),
    .result_ready_o(rready));
  adc_source_model src_u (.mclk_i, .go_i(go), .level_i(lvl), .adc_code_o(code),
    .adc_valid_o(vld));
  initial forever #2 mclk_i = ~mclk_i;
  task automatic give_verdict;
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge mclk_i);
    while (wt !== 1'b0) @(posedge mclk_i);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(n, e, q);
  endtask
  initial begin
    logic [31:0] e;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rchk("config", 5'h00, 32'h0);
    cmp("route", 32'h004, {23'h0, route});
    cmp("out1", 32'h800, {20'h0, out1});
    for (int m = 0; m < 3; m++) begin
      wreg(5'h00, m);
      rchk("config", 5'h00, m);
      for (int c = 0; c < 8; c += 7) begin
        wreg(5'h08, c);
        e = (m == 2) ? {c[1:0], 1'b0, c[1:0], 1'b1, 3'b001} : {c[2:0], 3'h0, 3'b100 >> m};
        cmp("route", e, {23'h0, route} & ((m == 2) ? 32'h1ff : 32'h1c7));
      end
      rchk("status", 5'h18, m << 1);
    end
    wreg(5'h00, 32'h3);
    rchk("config", 5'h00, 32'h2);
    wreg(5'h00, 32'h08);
    wreg(5'h0c, 32'h0fff);
    wreg(5'h10, 32'hf800);
    cmp("out0", 32'hfff, {20'h0, out0});
    cmp("out1", 32'h000, {20'h0, out1});
    wreg(5'h10, 32'h07ff);
    cmp("out1", 32'hfff, {20'h0, out1});
    for (int i = 0; i < 4; i++) begin
      wreg(5'h00, i[1] ? 32'h4 : 32'h0);
      lvl <= i[0] ? 12'hfff : 12'h000;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      repeat (3) @(posedge mclk_i);
      e = i[1] ? (i[0] ? 32'hfff : 32'h0) : (i[0] ? 32'h7ff : 32'hf800);
      cmp("ready", 32'h1, {31'h0, rready});
      rchk("status", 5'h18, 32'h1);
      rchk("result", 5'h14, e);
      rchk("status", 5'h18, 32'h0);
      cmp("ready", 32'h0, {31'h0, rready});
    end
    // A conversion pulse while the enable is low must leave the last result alone
    ce_i <= 1'b0;
    lvl <= 12'h5a5;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (3) @(posedge mclk_i);
    ce_i <= 1'b1;
    cmp("ready", 32'h0, {31'h0, rready});
    rchk("result", 5'h14, 32'hfff);
    wreg(5'h00, 32'h1d);
    wreg(5'h0c, 32'h0123);
    cmp("out0", 32'h123, {20'h0, out0});
    wreg(5'h04, 32'h1);
    rchk("config", 5'h00, 32'h0);
    cmp("out0", 32'h923, {20'h0, out0});
    cmp("route", 32'h1c4, {23'h0, route} & 32'h1c7);
    rchk("control", 5'h04, 32'h0);
    rchk("unmapped", 5'h1c, 32'h0);
    be <= 4'he;
    wreg(5'h08, 32'h3);
    be <= 4'hf;
    rchk("channel", 5'h08, 32'h7);
    rchk("out0 code", 5'h0c, 32'h123);
    rst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    cmp("out0", 32'h800, {20'h0, out0});
    rchk("channel", 5'h08, 32'h0);
    rchk("out0 code", 5'h0c, 32'h0);
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    give_verdict;
  end
endmodule
